// ### common/lic_pkg.sv
/*
 * Shared constants and carrier types for the line interface control block.
 * Assumes a single 10 MHz clock domain and a synchronous active-high reset.
 */
package lic_pkg;

    // ************************************************************
    // Clocking
    // ************************************************************
    localparam int unsigned CLK_HZ           = 10000000;   // System clock rate
    localparam int unsigned SETTLE_SAMPLES   = 1548;       // Off-hook settle, sample periods
    localparam int unsigned GROUP_DLY_SAMP   = 12;         // Filter group delay within settle

    // ************************************************************
    // Register field defaults
    // ************************************************************
    localparam logic [7:0] PLL1_PREDIV_RST   = 8'h00;      // Divider defaults
    localparam logic [7:0] PLL1_MULT_RST     = 8'h00;
    localparam logic [3:0] PLL2_PREDIV_RST   = 4'h0;
    localparam logic [3:0] PLL2_MULT_RST     = 4'h0;
    localparam logic [7:0] POWER_CTRL_RST    = 8'h10;      // Link powered down, pump off
    localparam int unsigned PUMP_BIT         = 7;          // Charge pump enable position
    localparam int unsigned LINK_PD_BIT      = 4;          // Link power-down position
    localparam logic [7:0] POWER_UP_VALUE    = 8'h80;      // Documented power-up write
    localparam logic [1:0] LEVEL_ADJ_RST     = 2'h0;

    // ************************************************************
    // Termination encodings
    // ************************************************************
    typedef enum logic [1:0] {
        LIC_DCT_RSVD  = 2'b00,
        LIC_DCT_JAPAN = 2'b01,
        LIC_DCT_FCC   = 2'b10,
        LIC_DCT_TBR21 = 2'b11
    } lic_dct_e;

    localparam lic_dct_e DCT_RST             = LIC_DCT_FCC;
    localparam logic     AC_REAL_600         = 1'b0;       // ac select: real termination
    localparam logic     AC_COMPLEX          = 1'b1;       // ac select: complex network

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic       pump_on;        // Charge pump enabled
        logic       line_chip_on;   // Line-side chip powered
        logic       monitor_on;     // Call monitor analog output on
        logic       link_up;        // Barrier link allowed
    } lic_power_s;

    typedef struct packed {
        logic       offhook;        // Hookswitch closed, loop current drawn
        logic       data_valid;     // Line data presented on serial link
        lic_dct_e   dc_mode;        // Active dc termination
        logic       ac_complex;     // Active ac termination
        logic       ramp_slow;      // Slow on-hook ramp
    } lic_line_s;

endpackage

// ### design/lic_line_ctrl.sv
/*
 * Control logic of a telephone-line access device: power-up, barrier link
 * gating, hook control with settling delay, and termination mode selection.
 * Assumes register writes arrive as per-register-group strobes with data from a
 * host port decoder, and a sample tick at the programmed sample rate.
 */
`timescale 1ns/1ps

// Operation
// - Reset release leaves all registers at default
// - Line-side chip stays powered down in reset
// - Writing 80 hex powers up pump and chip
// - Bit seven of register six enables pump
// - Barrier link disabled until power-down bit clears
// - Off-hook from low pin or register bit
// - Hook pin honoured only when enabled
// - Enabled pin low means off-hook, high on-hook
// - Line data appears 1548 samples after off-hook
// - Two-bit dc mode: Japan, FCC default, TBR21
// - Ac select: real 600 ohm or complex
module lic_line_ctrl
    import lic_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        wr_pll,               // Divider registers write strobe
    input  wire logic [7:0]  pll1_prediv_in,
    input  wire logic [7:0]  pll1_multiplier_in,
    input  wire logic [3:0]  pll2_prediv_in,
    input  wire logic [3:0]  pll2_multiplier_in,
    input  wire logic        wr_power,             // Register 6 write strobe
    input  wire logic [7:0]  power_ctrl_in,
    input  wire logic        wr_hook,              // Register 5 write strobe
    input  wire logic        hook_request_bit_in,
    input  wire logic        hook_pin_enable_in,
    input  wire logic        wr_line,              // Register 16/18 write strobe
    input  wire logic [1:0]  dc_termination_mode_in,
    input  wire logic        ac_impedance_select_in,
    input  wire logic        onhook_ramp_slow_in,
    input  wire logic [1:0]  line_level_adjust_in,
    input  wire logic        hook_request_pin,     // Active-low off-hook pin
    input  wire logic        sample_tick,          // One pulse per sample period
    output logic [7:0]       pll1_prediv,
    output logic [7:0]       pll1_multiplier,
    output logic [3:0]       pll2_prediv,
    output logic [3:0]       pll2_multiplier,
    output logic             link_power_down,
    output logic             charge_pump_en,
    output logic             line_chip_power,
    output logic             call_monitor_analog_out,
    output logic             offhook,
    output logic             line_data_valid,
    output logic [1:0]       dc_termination_mode,
    output logic             ac_impedance_select,
    output logic             onhook_ramp_slow,
    output logic [1:0]       line_level_adjust
);

    // ************************************************************
    // State
    // ************************************************************
    typedef enum {LIC_ONHOOK, LIC_SETTLE, LIC_ACTIVE} lic_hook_e;

    lic_hook_e   hook_r;                   // Hook sequencing state
    lic_hook_e   hook_nxt;
    logic [10:0] settle_cnt_r;             // Sample periods since off-hook
    logic [10:0] settle_cnt_nxt;
    logic [7:0]  power_r;                  // Register 6 image
    logic        hook_bit_r;               // Register hook request bit
    logic        pin_en_r;                 // Hook pin enable bit
    lic_power_s  pwr_w;                    // Decoded power controls
    lic_line_s   line_w;                   // Decoded line controls
    logic        offhook_req_w;            // Effective off-hook request

    localparam logic [10:0] SETTLE_LAST = 11'(SETTLE_SAMPLES - 1);

    // ************************************************************
    // Decode
    // ************************************************************
    // Pump follows bit 7; chip and monitor follow the power-up bit too
    assign pwr_w.pump_on      = power_r[PUMP_BIT];
    assign pwr_w.line_chip_on = power_r[PUMP_BIT];
    assign pwr_w.monitor_on   = power_r[PUMP_BIT];
    assign pwr_w.link_up      = ~power_r[LINK_PD_BIT];

    // Pin term gated by enable, inverted, ORed with the bit
    assign offhook_req_w = hook_bit_r | (pin_en_r & ~hook_request_pin);

    // Line data only with link up and settle complete
    assign line_w.offhook    = (hook_r != LIC_ONHOOK);
    assign line_w.data_valid = (hook_r == LIC_ACTIVE) & pwr_w.link_up;

    // Termination fields mirrored into the line carrier
    assign line_w.dc_mode    = lic_dct_e'(dc_termination_mode);
    assign line_w.ac_complex = ac_impedance_select;
    assign line_w.ramp_slow  = onhook_ramp_slow;

    // Hook sequencer next state
    always_comb begin
        hook_nxt       = hook_r;
        settle_cnt_nxt = settle_cnt_r;
        case (hook_r)
            LIC_ONHOOK: begin
                settle_cnt_nxt = '0;
                if (offhook_req_w && pwr_w.line_chip_on) begin
                    hook_nxt = LIC_SETTLE;
                end
            end
            LIC_SETTLE: begin
                if (!offhook_req_w) begin
                    hook_nxt = LIC_ONHOOK;
                end else if (sample_tick) begin
                    if (settle_cnt_r == SETTLE_LAST) begin
                        hook_nxt = LIC_ACTIVE;
                    end else begin
                        settle_cnt_nxt = settle_cnt_r + 11'h001;
                    end
                end
            end
            LIC_ACTIVE: begin
                if (!offhook_req_w || !pwr_w.line_chip_on) begin
                    hook_nxt = LIC_ONHOOK;
                end
            end
            default: begin
                hook_nxt = LIC_ONHOOK;
            end
        endcase
        if (!pwr_w.line_chip_on) begin
            hook_nxt = LIC_ONHOOK;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Control registers with defaults on reset
    always_ff @(posedge clk) begin
        if (reset) begin
            pll1_prediv         <= PLL1_PREDIV_RST;
            pll1_multiplier     <= PLL1_MULT_RST;
            pll2_prediv         <= PLL2_PREDIV_RST;
            pll2_multiplier     <= PLL2_MULT_RST;
            power_r             <= POWER_CTRL_RST;
            hook_bit_r          <= 1'b0;
            pin_en_r            <= 1'b0;
            dc_termination_mode <= DCT_RST;
            ac_impedance_select <= AC_REAL_600;
            onhook_ramp_slow    <= 1'b0;
            line_level_adjust   <= LEVEL_ADJ_RST;
        end else begin
            if (wr_pll) begin
                pll1_prediv     <= pll1_prediv_in;
                pll1_multiplier <= pll1_multiplier_in;
                pll2_prediv     <= pll2_prediv_in;
                pll2_multiplier <= pll2_multiplier_in;
            end
            if (wr_power) begin
                power_r <= power_ctrl_in;
            end
            if (wr_hook) begin
                hook_bit_r <= hook_request_bit_in;
                pin_en_r   <= hook_pin_enable_in;
            end
            if (wr_line) begin
                dc_termination_mode <= dc_termination_mode_in;
                ac_impedance_select <= ac_impedance_select_in;
                onhook_ramp_slow    <= onhook_ramp_slow_in;
                line_level_adjust   <= line_level_adjust_in;
            end
        end
    end

    // Sequencer and registered outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            hook_r                  <= LIC_ONHOOK;
            settle_cnt_r            <= '0;
            link_power_down         <= 1'b1;
            charge_pump_en          <= 1'b0;
            line_chip_power         <= 1'b0;
            call_monitor_analog_out <= 1'b0;
            offhook                 <= 1'b0;
            line_data_valid         <= 1'b0;
        end else begin
            hook_r                  <= hook_nxt;
            settle_cnt_r            <= settle_cnt_nxt;
            link_power_down         <= ~pwr_w.link_up;
            charge_pump_en          <= pwr_w.pump_on;
            line_chip_power         <= pwr_w.line_chip_on;
            call_monitor_analog_out <= pwr_w.monitor_on;
            offhook                 <= line_w.offhook;
            line_data_valid         <= line_w.data_valid;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    chk_reset_chip_off: assert property (@(posedge clk)
        reset |=> !line_chip_power && !offhook && link_power_down)
        else $error("line chip not off after reset");

    chk_pump_follows_bit: assert property (@(posedge clk) disable iff (reset)
        power_r[PUMP_BIT] |=> charge_pump_en)
        else $error("charge pump not enabled");

    chk_link_gates_data: assert property (@(posedge clk) disable iff (reset)
        link_power_down |-> !line_data_valid)
        else $error("data valid with link down");

    chk_pin_offhook: assert property (@(posedge clk) disable iff (reset)
        (pin_en_r && !hook_request_pin && line_chip_power && hook_r == LIC_ONHOOK
         && power_r[PUMP_BIT]) ##1 pwr_w.line_chip_on |=> offhook)
        else $error("pin off-hook not honoured");

    chk_pin_disabled: assert property (@(posedge clk) disable iff (reset)
        (!pin_en_r && !hook_bit_r && hook_r == LIC_ONHOOK) |=> hook_r == LIC_ONHOOK)
        else $error("disabled pin caused off-hook");

    chk_settle_early: assert property (@(posedge clk) disable iff (reset)
        (hook_r == LIC_SETTLE && settle_cnt_r < SETTLE_LAST) |=> hook_r != LIC_ACTIVE)
        else $error("settle ended early");

    chk_settle_done: assert property (@(posedge clk) disable iff (reset)
        (hook_r == LIC_SETTLE && settle_cnt_r == SETTLE_LAST && sample_tick
         && offhook_req_w && pwr_w.line_chip_on) |=> hook_r == LIC_ACTIVE)
        else $error("settle did not complete");

    chk_dct_default: assert property (@(posedge clk)
        reset |=> dc_termination_mode == LIC_DCT_FCC && ac_impedance_select == AC_REAL_600)
        else $error("termination default wrong");

    chk_bit_offhook: assert property (@(posedge clk) disable iff (reset)
        $rose(hook_r == LIC_SETTLE) |-> $past(offhook_req_w))
        else $error("off-hook without request");

endmodule

// ### testbench/lic_host_model.sv
/* Host model: drives the register write strobes and their data.
   Assumes the bench owns clock, reset, hook pin and sample tick. */
`timescale 1ns/1ps
module lic_host_model
    import lic_pkg::*;
#(
    parameter int LOCK_CYCLES = 1000   // Lock wait, 100 us at 10 MHz
)
(
    input  wire logic  clk,
    output logic       wr_pll,
    output logic [7:0] pll1_prediv_in,
    output logic [7:0] pll1_multiplier_in,
    output logic [3:0] pll2_prediv_in,
    output logic [3:0] pll2_multiplier_in,
    output logic       wr_power,
    output logic [7:0] power_ctrl_in,
    output logic       wr_hook,
    output logic       hook_request_bit_in,
    output logic       hook_pin_enable_in,
    output logic       wr_line,
    output logic [1:0] dc_termination_mode_in,
    output logic       ac_impedance_select_in,
    output logic       onhook_ramp_slow_in,
    output logic [1:0] line_level_adjust_in
);
    // ****************************************
    // Host port tasks
    // ****************************************
    // Idle port at time zero
    initial begin
        {wr_pll, wr_power, wr_hook, wr_line} = 4'h0;
        {pll1_prediv_in, pll1_multiplier_in, pll2_prediv_in, pll2_multiplier_in} = 24'h0;
        {power_ctrl_in, hook_request_bit_in, hook_pin_enable_in} = 10'h0;
        {dc_termination_mode_in, ac_impedance_select_in} = 3'h0;
        {onhook_ramp_slow_in, line_level_adjust_in} = 3'h0;
    end

    // Divider load, first step of bring-up
    task automatic load_dividers(input logic [23:0] v);
        @(negedge clk);
        {pll1_prediv_in, pll1_multiplier_in, pll2_prediv_in, pll2_multiplier_in} = v;
        wr_pll = 1'b1;
        @(negedge clk);
        wr_pll = 1'b0;
        {pll1_prediv_in, pll1_multiplier_in, pll2_prediv_in, pll2_multiplier_in} = ~v;
    endtask

    // Synthesizer lock wait before power-up
    task automatic wait_lock();
        repeat (LOCK_CYCLES) @(negedge clk);
    endtask

    // Power register write, data inverted after strobe
    task automatic write_power(input logic [7:0] v);
        @(negedge clk);
        power_ctrl_in = v;
        wr_power = 1'b1;
        @(negedge clk);
        wr_power = 1'b0;
        power_ctrl_in = ~v;
    endtask

    // Hook register write
    task automatic write_hook(input logic b, input logic e);
        @(negedge clk);
        {hook_request_bit_in, hook_pin_enable_in} = {b, e};
        wr_hook = 1'b1;
        @(negedge clk);
        wr_hook = 1'b0;
        {hook_request_bit_in, hook_pin_enable_in} = ~{b, e};
    endtask

    // Country line fields, last bring-up step
    task automatic write_line(input logic [5:0] v);
        @(negedge clk);
        {dc_termination_mode_in, ac_impedance_select_in, onhook_ramp_slow_in,
         line_level_adjust_in} = v;
        wr_line = 1'b1;
        @(negedge clk);
        wr_line = 1'b0;
        {dc_termination_mode_in, ac_impedance_select_in, onhook_ramp_slow_in,
         line_level_adjust_in} = ~v;
    endtask
endmodule

// ### testbench/test_lic_line_ctrl.sv
/* Self-checking bench for the line interface control block.
   Assumes the host model for writes; bench drives pin and tick. */
`timescale 1ns/1ps
module test_lic_line_ctrl;
    import lic_pkg::*;
    logic       clk, reset, hook_request_pin, sample_tick;   // Bench driven
    logic       wr_pll, wr_power, wr_hook, wr_line;          // Host strobes
    logic [7:0] pll1_prediv_in, pll1_multiplier_in, power_ctrl_in;
    logic [3:0] pll2_prediv_in, pll2_multiplier_in;
    logic       hook_request_bit_in, hook_pin_enable_in;
    logic       ac_impedance_select_in, onhook_ramp_slow_in;
    logic [1:0] dc_termination_mode_in, line_level_adjust_in;
    logic [7:0] pll1_prediv, pll1_multiplier;
    logic [3:0] pll2_prediv, pll2_multiplier;
    logic       link_power_down, charge_pump_en, line_chip_power, call_monitor_analog_out;
    logic       offhook, line_data_valid, ac_impedance_select, onhook_ramp_slow;
    logic [1:0] dc_termination_mode, line_level_adjust;
    int         fails, check_count;                          // Tallies
    localparam int SEIZE_HOLD_CYCLES = 50;   // Seize-to-hold wait, scaled down for run time
    wire  [7:0] pwr_v  = {4'h0, link_power_down, charge_pump_en, line_chip_power,
                          call_monitor_analog_out};
    wire  [7:0] line_v = {offhook, line_data_valid, dc_termination_mode,
                          ac_impedance_select, onhook_ramp_slow, line_level_adjust};

    lic_line_ctrl u_lic_line_ctrl (.clk, .reset, .wr_pll, .pll1_prediv_in,
        .pll1_multiplier_in, .pll2_prediv_in, .pll2_multiplier_in, .wr_power,
        .power_ctrl_in, .wr_hook, .hook_request_bit_in, .hook_pin_enable_in, .wr_line,
        .dc_termination_mode_in, .ac_impedance_select_in, .onhook_ramp_slow_in,
        .line_level_adjust_in, .hook_request_pin, .sample_tick, .pll1_prediv,
        .pll1_multiplier, .pll2_prediv, .pll2_multiplier, .link_power_down,
        .charge_pump_en, .line_chip_power, .call_monitor_analog_out, .offhook,
        .line_data_valid, .dc_termination_mode, .ac_impedance_select,
        .onhook_ramp_slow, .line_level_adjust);
    lic_host_model u_lic_host_model (.clk, .wr_pll, .pll1_prediv_in,
        .pll1_multiplier_in, .pll2_prediv_in, .pll2_multiplier_in, .wr_power,
        .power_ctrl_in, .wr_hook, .hook_request_bit_in, .hook_pin_enable_in, .wr_line,
        .dc_termination_mode_in, .ac_impedance_select_in, .onhook_ramp_slow_in,
        .line_level_adjust_in);

    // ****************************************
    // Helpers
    // ****************************************
    // 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Compare and tally
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Sample ticks, one every two clocks: raised rate shortens settling
    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge clk) sample_tick = 1'b1;
            @(negedge clk) sample_tick = 1'b0;
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    // Reset for four clocks, then defaults
    task automatic t_reset();
        @(negedge clk) reset = 1'b1;
        repeat (4) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        check("pll1", {pll1_prediv | pll1_multiplier}, 8'h00);
        check("pll2", {pll2_prediv, pll2_multiplier}, 8'h00);
        check("power", pwr_v, 8'h08);
        check("line", line_v, 8'h20);
        $display("reset test done");
    endtask

    // Off-hook refused while powered down, then bring-up
    task automatic t_power();
        u_lic_host_model.write_hook(1'b1, 1'b0);
        repeat (4) @(negedge clk);
        check("offhook unpowered", {7'h0, offhook}, 8'h00);
        u_lic_host_model.write_hook(1'b0, 1'b0);
        u_lic_host_model.load_dividers(24'ha5_3c_96);
        u_lic_host_model.wait_lock();
        check("pll1 prediv", pll1_prediv, 8'ha5);
        check("pll1 mult", pll1_multiplier, 8'h3c);
        check("pll2", {pll2_prediv, pll2_multiplier}, 8'h96);
        u_lic_host_model.write_power(POWER_UP_VALUE);
        repeat (3) @(negedge clk);
        check("power up", pwr_v, 8'h07);
        $display("power test done");
    endtask

    // Pin and register hook requests
    task automatic t_hook();
        hook_request_pin = 1'b0;
        repeat (4) @(negedge clk);
        check("pin disabled", {7'h0, offhook}, 8'h00);
        u_lic_host_model.write_hook(1'b0, 1'b1);
        repeat (4) @(negedge clk);
        check("pin low", {7'h0, offhook}, 8'h01);
        hook_request_pin = 1'b1;
        repeat (4) @(negedge clk);
        check("pin high", {7'h0, offhook}, 8'h00);
        u_lic_host_model.write_hook(1'b1, 1'b1);
        repeat (4) @(negedge clk);
        check("bit set", {7'h0, offhook}, 8'h01);
        u_lic_host_model.write_hook(1'b0, 1'b0);
        repeat (4) @(negedge clk);
        $display("hook test done");
    endtask

    // Line data only after the settle count
    task automatic t_settle();
        u_lic_host_model.write_hook(1'b1, 1'b0);
        for (int i = 0; i < 20 && offhook !== 1'b1; i++) @(negedge clk);
        check("settle offhook", {7'h0, offhook}, 8'h01);
        ticks(SETTLE_SAMPLES - 1);
        repeat (2) @(negedge clk);
        check("early data", {7'h0, line_data_valid}, 8'h00);
        ticks(1);
        repeat (2) @(negedge clk);
        check("late data", {7'h0, line_data_valid}, 8'h01);
        u_lic_host_model.write_hook(1'b0, 1'b0);
        repeat (4) @(negedge clk);
        check("dropped", line_v[7:6], 8'h00);
        $display("settle test done");
    endtask

    // Every dc mode, both ac choices, level field
    task automatic t_line();
        for (int i = 1; i < 4; i++) begin
            u_lic_host_model.write_line({i[1:0], i[0], i[1], i[1:0]});
            repeat (2) @(negedge clk);
            check("line", {2'h0, line_v[5:0]}, {2'h0, i[1:0], i[0], i[1], i[1:0]});
        end
        $display("line test done");
    endtask

    // Country procedures: Japan seize then FCC hold, TBR21 fallback
    task automatic t_country();
        u_lic_host_model.write_line({LIC_DCT_JAPAN, AC_REAL_600, 1'b0, 2'h1});
        u_lic_host_model.write_hook(1'b1, 1'b0);
        for (int i = 0; i < 20 && offhook !== 1'b1; i++) @(negedge clk);
        check("seize japan", line_v, 8'h91);
        repeat (SEIZE_HOLD_CYCLES) @(negedge clk);
        u_lic_host_model.write_line({LIC_DCT_FCC, AC_REAL_600, 1'b0, 2'h0});
        repeat (2) @(negedge clk);
        check("hold fcc", line_v, 8'ha0);
        u_lic_host_model.write_line({LIC_DCT_TBR21, AC_COMPLEX, 1'b0, 2'h0});
        repeat (2) @(negedge clk);
        check("tbr21", line_v, 8'hb8);
        u_lic_host_model.write_line({LIC_DCT_FCC, AC_COMPLEX, 1'b0, 2'h0});
        repeat (2) @(negedge clk);
        check("low current fcc", line_v, 8'ha8);
        u_lic_host_model.write_hook(1'b0, 1'b0);
        repeat (4) @(negedge clk);
        check("country onhook", {7'h0, offhook}, 8'h00);
        $display("country test done");
    endtask

    // Counts and verdict
    task automatic print_verdict();
        $display("checks %0d failures %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence, reset repeated at the end
    initial begin
        {reset, hook_request_pin, sample_tick} = 3'b110;
        t_reset();
        t_power();
        t_hook();
        t_settle();
        t_line();
        t_country();
        t_reset();
        print_verdict();
    end

    // Hang guard, nearly five times the expected run
    initial begin
        #2000000;
        fails++;
        print_verdict();
    end
endmodule
